// ---- inc/fsw_consts.svh ----
`ifndef FSW_CONSTS_SVH
`define FSW_CONSTS_SVH
// Block number width
`define FSW_BLK_W        8
// Window bounds after reset: whole flash open
`define FSW_START_RST    8'h00
`define FSW_END_RST      8'hff
// Flash block size in bytes and boot cluster size in bytes
`define FSW_BLOCK_BYTES  32'h400
`define FSW_CLUSTER_BYTES 32'h1000
// Boot cluster 0 starts at address zero
`define FSW_BC0_BASE     20'h00000
// Last byte of boot cluster 0
`define FSW_BC0_LAST     (`FSW_BC0_BASE + `FSW_CLUSTER_BYTES - 32'h1)
// Address width
`define FSW_ADDR_W       20
`endif

// ---- inc/fsw_pkg.sv ----
package fsw_pkg;
  // Kind of flash request
  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_WRITE = 2'b01,
    OP_ERASE = 2'b11
  } fsw_op_t;
  // Programming context of the request
  typedef enum logic {
    CTX_SELF = 1'b0,
    CTX_EXT  = 1'b1
  } fsw_ctx_t;
endpackage : fsw_pkg

// ---- rtl/flash_shield_window_guard.sv ----
`timescale 1ns/10ps
`include "fsw_consts.svh"
// Contract
// - Self programming: refuse outside window, allow inside
// - Window is first block to last block
// - Bounds settable in self and external programming
// - External programming ignores window
// - Boot cluster 0 prohibition overrides window
// - Boot cluster spans exactly 4 KB
module flash_shield_window_guard #(
  parameter int ADDR_W = `FSW_ADDR_W,
  parameter int BLK_W  = `FSW_BLK_W
) (
  input  wire logic              core_clk_in,    // System clock, 50 MHz
  input  wire logic              rst_b_in,       // Async reset, active low
  input  wire fsw_pkg::fsw_ctx_t ctx_in,         // Self or external programming
  input  wire logic              win_set_in,     // Load window bounds, pulse
  input  wire logic [BLK_W-1:0]  win_start_in,   // New first block
  input  wire logic [BLK_W-1:0]  win_end_in,     // New last block
  input  wire logic              bc0_protect_in, // Boot cluster 0 rewrite prohibited
  input  wire logic              req_valid_in,   // Request strobe, pulse
  input  wire fsw_pkg::fsw_op_t  req_op_in,      // Write or block erase
  input  wire logic [ADDR_W-1:0] req_addr_in,    // Target byte address
  output logic                   grant_out,      // Request allowed, pulse
  output logic                   fail_out,       // Request refused, pulse
  output logic [BLK_W-1:0]       win_start_out,  // Current first block
  output logic [BLK_W-1:0]       win_end_out     // Current last block
);
  import fsw_pkg::*;

  // Shift amounts follow block and cluster sizes
  localparam int BLK_SH = $clog2(`FSW_BLOCK_BYTES);   // Byte address to block number
  localparam int BC_SH  = $clog2(`FSW_CLUSTER_BYTES); // Byte address to cluster number

  logic [BLK_W-1:0] win_start_ff; // First writable block
  logic [BLK_W-1:0] win_end_ff;   // Last writable block
  logic             grant_ff;     // Registered grant
  logic             fail_ff;      // Registered failure
  logic [BLK_W-1:0] req_blk;      // Block of the request
  logic             in_window;    // Block inside the window
  logic             in_bc0;       // Address inside boot cluster 0
  logic             is_op;        // Valid write or erase
  logic             allow;        // Final decision

  // Window bounds, loadable in either context
  // A load and a request in one cycle: the request
  // still sees the bounds stored before the load
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      win_start_ff <= `FSW_START_RST;
      win_end_ff   <= `FSW_END_RST;
    end
    else if (win_set_in)
    begin
      // No context check: both contexts may set bounds
      win_start_ff <= win_start_in;
      win_end_ff   <= win_end_in;
    end
  end

  // Block number from byte address
  assign req_blk = BLK_W'(req_addr_in >> BLK_SH);

  // Inclusive window compare
  fsw_bound_cmp #(
    .BLK_W (BLK_W)
  ) u_cmp (
    .blk_in     (req_blk),
    .lo_in      (win_start_ff),
    .hi_in      (win_end_ff),
    .inside_out (in_window)
  );

  // Boot cluster 0 is one 4 KB span from its base
  assign in_bc0 = ((req_addr_in >> BC_SH) == (ADDR_W'(`FSW_BC0_BASE) >> BC_SH));

  assign is_op = req_valid_in && ((req_op_in == OP_WRITE) || (req_op_in == OP_ERASE));

  // Decision: boot cluster first, then context, then window
  // Lock order matters: the boot cluster lock must
  // beat both the external bypass and the window
  always_comb
  begin
    if (bc0_protect_in && in_bc0)
      allow = 1'b0;
    else if (ctx_in == CTX_EXT)
      allow = 1'b1;
    else
      allow = in_window;
  end

  // One-cycle answer per request
  // Unknown operation codes fall through with no answer
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      grant_ff <= 1'b0;
      fail_ff  <= 1'b0;
    end
    else
    begin
      grant_ff <= is_op && allow;
      fail_ff  <= is_op && !allow;
    end
  end

  assign grant_out     = grant_ff;
  assign fail_out      = fail_ff;
  assign win_start_out = win_start_ff;
  assign win_end_out   = win_end_ff;

  // Checks on the decision path
  // Self request with no boot cluster lock in play
  sequence s_self_req;
    is_op && (ctx_in == CTX_SELF) && !(bc0_protect_in && in_bc0);
  endsequence

  // Refusal: fail alone, no grant
  sequence s_refused;
    fail_out && !grant_out;
  endsequence

  // Grant: grant alone, no fail
  sequence s_granted;
    grant_out && !fail_out;
  endsequence

  // Self programming outside window fails next cycle
  property p_self_outside;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (is_op && ctx_in == CTX_SELF && !in_window) |=> (fail_out && !grant_out);
  endproperty
  a_self_outside: assert property (p_self_outside) else $error("outside refused missed");

  // Self programming inside window, no boot hit, granted
  property p_self_inside;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (is_op && ctx_in == CTX_SELF && in_window && !(bc0_protect_in && in_bc0)) |=> grant_out;
  endproperty
  a_self_inside: assert property (p_self_inside) else $error("inside grant missed");

  // Bounds follow a load
  property p_load;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    win_set_in |=> (win_start_out == $past(win_start_in) && win_end_out == $past(win_end_in));
  endproperty
  a_load: assert property (p_load) else $error("window load lost");

  // Bounds hold without a load
  property p_hold;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    !win_set_in |=> $stable(win_start_out) && $stable(win_end_out);
  endproperty
  a_hold: assert property (p_hold) else $error("window changed");

  // External context ignores window
  property p_ext;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (is_op && ctx_in == CTX_EXT && !(bc0_protect_in && in_bc0)) |=> grant_out;
  endproperty
  a_ext: assert property (p_ext) else $error("external refused");

  // Boot cluster prohibition wins
  property p_bc0;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (is_op && bc0_protect_in && in_bc0) |=> (fail_out && !grant_out);
  endproperty
  a_bc0: assert property (p_bc0) else $error("boot cluster rewritten");

  // Cluster span is exactly 4 KB
  property p_span;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    in_bc0 == (req_addr_in < ADDR_W'(`FSW_CLUSTER_BYTES));
  endproperty
  a_span: assert property (p_span) else $error("cluster span wrong");

  // Exactly one answer per request, none otherwise
  property p_answer;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    1'b1 |=> ((grant_out || fail_out) == $past(is_op)) && !(grant_out && fail_out);
  endproperty
  a_answer: assert property (p_answer) else $error("answer mismatch");

  // Self request on either bound of a proper window passes
  property p_edge_blk;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    s_self_req ##0 ((req_blk == win_start_out) || (req_blk == win_end_out))
      ##0 (win_start_out <= win_end_out) |=> s_granted;
  endproperty
  a_edge_blk: assert property (p_edge_blk) else $error("window bound refused");

  // Start above end leaves no writable block
  property p_empty_win;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    s_self_req ##0 (win_start_out > win_end_out) |=> s_refused;
  endproperty
  a_empty_win: assert property (p_empty_win) else $error("empty window granted");

  // Unknown operation codes draw no answer
  property p_no_op;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (req_valid_in && !is_op) |=> (!grant_out && !fail_out);
  endproperty
  a_no_op: assert property (p_no_op) else $error("answer to no operation");

  // Last byte of boot cluster 0 still locked
  property p_bc0_last;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (is_op && bc0_protect_in && (req_addr_in == ADDR_W'(`FSW_BC0_LAST))) |=> s_refused;
  endproperty
  a_bc0_last: assert property (p_bc0_last) else $error("cluster end unlocked");

  // First byte past boot cluster 0 free in external programming
  property p_bc0_next;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (is_op && (ctx_in == CTX_EXT) &&
      (req_addr_in == ADDR_W'(`FSW_BC0_BASE + `FSW_CLUSTER_BYTES))) |=> s_granted;
  endproperty
  a_bc0_next: assert property (p_bc0_next) else $error("lock spills past cluster");
endmodule : flash_shield_window_guard

// ---- rtl/fsw_bound_cmp.sv ----
`timescale 1ns/10ps
`include "fsw_consts.svh"
// Inclusive range compare of a block number
module fsw_bound_cmp #(
  parameter int BLK_W = `FSW_BLK_W
) (
  input  wire logic [BLK_W-1:0] blk_in,    // Block under test
  input  wire logic [BLK_W-1:0] lo_in,     // First block
  input  wire logic [BLK_W-1:0] hi_in,     // Last block
  output logic                  inside_out // Block within bounds
);
  // Both ends count as inside
  assign inside_out = (blk_in >= lo_in) && (blk_in <= hi_in);
endmodule : fsw_bound_cmp

// ---- test/flash_seq_model.sv ----
`timescale 1ns/10ps
// Requester: one request per go cycle
module flash_seq_model (
  input  wire logic             clk_in,    // Clock
  input  wire logic             go_in,     // Issue now
  input  wire fsw_pkg::fsw_op_t op_in,     // Operation
  input  wire logic [19:0]      addr_in,   // Address
  output logic                  valid_out, // Strobe
  output fsw_pkg::fsw_op_t      op_out,    // Operation out
  output logic [19:0]           addr_out   // Address out
);
  import fsw_pkg::*;
  // Idle address shows the inverse of the last one
  always_ff @(posedge clk_in)
  begin
    valid_out <= go_in;
    op_out    <= go_in ? op_in : OP_NONE;
    addr_out  <= go_in ? addr_in : ~addr_in;
  end
endmodule : flash_seq_model

// ---- test/flash_shield_window_guard_tb_top.sv ----
`timescale 1ns/10ps
module flash_shield_window_guard_tb_top;
  import fsw_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, go = 1'b0, ld = 1'b0, bc0 = 1'b0;
  fsw_ctx_t ctx = CTX_SELF;
  fsw_op_t op = OP_WRITE, rop;
  logic [19:0] ad = 20'h0, rad;
  logic [7:0] ws = 8'h0, we = 8'h0, sm = 8'h0, em = 8'hff, so, eo;
  logic v, gr, fl;
  logic [1:0] q[$]; // Expected grant,fail
  int n_errors = 0, comparisons = 0;
  always #10 clk = ~clk;
  flash_seq_model seq (.clk_in(clk), .go_in(go), .op_in(op), .addr_in(ad),
    .valid_out(v), .op_out(rop), .addr_out(rad));
  flash_shield_window_guard dut (.core_clk_in(clk), .rst_b_in(rst_b), .ctx_in(ctx),
    .win_set_in(ld), .win_start_in(ws), .win_end_in(we), .bc0_protect_in(bc0),
    .req_valid_in(v), .req_op_in(rop), .req_addr_in(rad), .grant_out(gr),
    .fail_out(fl), .win_start_out(so), .win_end_out(eo));
  task check(input logic [7:0] seen, input logic [7:0] exp, input string m);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : check
  // Request plus its expected answer
  task issue(input fsw_op_t o, input logic [19:0] a);
    @(posedge clk);
    go <= 1'b1;
    op <= o;
    ad <= a;
    if (o[0])
      q.push_back(((bc0 && a < 20'h01000) || (ctx == CTX_SELF &&
        (a[17:10] < sm || a[17:10] > em))) ? 2'b01 : 2'b10);
  endtask : issue
  task cfg(input fsw_ctx_t c, input logic p);
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    ctx <= c;
    bc0 <= p;
  endtask : cfg
  // Load bounds; in-flight request keeps old bounds
  task load(input logic [7:0] s, input logic [7:0] e);
    @(posedge clk);
    go <= 1'b0;
    ld <= 1'b1;
    ws <= s;
    we <= e;
    @(posedge clk);
    ld <= 1'b0;
    sm = s;
    em = e;
    @(posedge clk);
    #1;
    check(so, s, "start");
    check(eo, e, "end");
  endtask : load
  task close_out;
    check(8'(q.size()), 8'h00, "no answer");
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  // Answer monitor
  always @(negedge clk)
    if (gr === 1'b1 || fl === 1'b1)
      check({6'h0, gr, fl}, q.size() ? {6'h0, q.pop_front()} : 8'hff, "answer");
  initial
  begin
    #200us;
    n_errors++;
    close_out;
  end
  initial
  begin
    void'($urandom(32'h1b0c3184));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    check(so, 8'h00, "reset start");
    check(eo, 8'hff, "reset end");
    issue(OP_WRITE, 20'h3fc00);
    load(8'h04, 8'h06);
    for (int b = 3; b < 8; b++) issue(b[0] ? OP_ERASE : OP_WRITE, {2'h0, 8'(b), 10'h3ff});
    issue(OP_NONE, 20'h01000);
    issue(fsw_op_t'(2'b10), 20'h01000);
    cfg(CTX_EXT, 1'b0);
    load(8'h05, 8'h05);
    for (int b = 3; b < 8; b++) issue(OP_ERASE, {2'h0, 8'(b), 10'h000});
    for (int c = 0; c < 2; c++)
    begin
      cfg(fsw_ctx_t'(c[0]), 1'b1);
      issue(OP_WRITE, 20'h00fff);
      issue(OP_ERASE, 20'h01000);
    end
    cfg(CTX_SELF, 1'b0);
    load(8'h07, 8'h02);
    issue(OP_WRITE, 20'h01c00);
    repeat (6)
    begin
      cfg(fsw_ctx_t'(1'($urandom)), 1'($urandom));
      load(8'($urandom), 8'($urandom));
      repeat (8) issue($urandom % 2 ? OP_ERASE : OP_WRITE, {2'h0, 18'($urandom)});
    end
    cfg(CTX_SELF, 1'b0);
    repeat (3) @(posedge clk);
    close_out;
  end
endmodule : flash_shield_window_guard_tb_top
